/* src/ceau_map.vh */
// Constants of the exception acceptance unit: offsets, fields, codes, vectors.
// Assumes a 32-bit core with 16-bit instructions and a same-clock pipeline.
// Summary of operation
// RL1 - Four acceptance levels: resets highest, external and debug interrupts lowest.
// RL2 - Same-cycle events: highest level wins; resets and interrupts are asynchronous.
// RL3 - General exceptions at level 2, earlier instruction's exception taken first.
// RL4 - Reserved, trap and slot-illegal exceptions share one execution priority.
// RL5 - Non-reset exceptions taken at boundaries, never between branch and slot.
// RL6 - Re-execution exception in a slot is taken before its branch.
// RL7 - Slot follows unconditional delayed branch, or conditional one when true.
// RL8 - Power-on and debug reset write 000, manual reset writes 020.
// RL9 - Miss or invalid: 040 read, 060 write, 070 inside a repeat loop.
// RL10 - Initial page write 080; protection 0A0 read, 0C0 write, 0D0 loop.
// RL11 - Address error 0E0 read, 100 write; trap instruction 160.
// RL12 - Illegal 180, slot illegal 1A0, user break 1E0, DMA error 5C0.
// RL13 - Interrupt codes: NMI 1C0, debug 5E0, levels 200 plus 20 per step.
// RL14 - Block bit 0: exceptions and interrupts are accepted.
// RL15 - Exception with block bit 1: reinit CPU state, branch to A0000000.
// RL16 - Interrupt with block bit 1 stays pending until block bit cleared.
// RL17 - Return: saved PC to PC, saved status to status, branch there.
// RL18 - Event registers respond only to privileged accesses.
// RL19 - Exception event register holds 12-bit code in bits 11..0, writable.
// RL20 - Interrupt event register takes code or priority code by source.
// RL21 - Second interrupt event register takes the interrupt code always.
// RL22 - Trap immediate stored in bits 9..2, other bits zero, writable.
// RL23 - On accept: save PC and status, set block, mode, bank, write code.
// RL24 - Resets vector to A0000000; others to base plus 400, 100 or 600.
`ifndef CEAU_MAP_VH
`define CEAU_MAP_VH
// ****************
// Register offsets
// ****************
`define CEAU_ADR_TRA   32'h0fffffd0
`define CEAU_ADR_EXP   32'h0fffffd4
`define CEAU_ADR_INT   32'h0fffffd8
`define CEAU_ADR_INT2  32'h04000000
// ****************
// Status fields
// ****************
`define CEAU_SR_MD     30
`define CEAU_SR_RB     29
`define CEAU_SR_BL     28
`define CEAU_SR_RST    32'h700000f0
`define CEAU_SR_ENTRY  32'h70000000
`define CEAU_TRA_LSB   2
// ****************
// Vectors
// ****************
`define CEAU_VEC_RST   32'ha0000000
`define CEAU_OFF_MISS  32'h00000400
`define CEAU_OFF_GEN   32'h00000100
`define CEAU_OFF_IRQ   32'h00000600
// ****************
// Exception kinds
// ****************
`define CEAU_K_MISS    4'h0
`define CEAU_K_INV     4'h1
`define CEAU_K_PROT    4'h2
`define CEAU_K_ADDR    4'h3
`define CEAU_K_IPW     4'h4
`define CEAU_K_TRAP    4'h5
`define CEAU_K_ILL     4'h6
`define CEAU_K_SLOT    4'h7
`define CEAU_K_UBRK    4'h8
`define CEAU_K_DMA     4'h9
// ****************
// Event codes
// ****************
`define CEAU_C_PON     12'h000
`define CEAU_C_MAN     12'h020
`define CEAU_C_TLBR    12'h040
`define CEAU_C_TLBW    12'h060
`define CEAU_C_LOOP    12'h070
`define CEAU_C_IPW     12'h080
`define CEAU_C_PROR    12'h0a0
`define CEAU_C_PROW    12'h0c0
`define CEAU_C_PROL    12'h0d0
`define CEAU_C_ADRR    12'h0e0
`define CEAU_C_ADRW    12'h100
`define CEAU_C_TRAP    12'h160
`define CEAU_C_ILL     12'h180
`define CEAU_C_SLOT    12'h1a0
`define CEAU_C_UBRK    12'h1e0
`define CEAU_C_DMA     12'h5c0
`define CEAU_C_NMI     12'h1c0
`define CEAU_C_DBGI    12'h5e0
`define CEAU_C_LVL0    12'h200
`endif

/* src/ceau_code.v */
// Event code encoder: maps an exception kind or level to its 12-bit code.
// Pure combinational; the caller registers every result.
`timescale 1ns/1ps
`include "ceau_map.vh"
module ceau_code (
	// Exception description
	input  wire [3:0]  i_kind,
	input  wire        i_wr,
	input  wire        i_loop,
	// Interrupt level
	input  wire [3:0]  i_level,
	// Results
	output reg  [11:0] o_exc_code,
	output reg         o_miss_vec,
	output reg         o_complete,
	output wire [11:0] o_lvl_code
);
	// ****************
	// Level code
	// ****************
	assign o_lvl_code = `CEAU_C_LVL0 + {3'h0, i_level, 5'h00}; // RL13

	// ****************
	// Exception code
	// ****************
	always @* begin
		o_miss_vec = 1'b0;
		o_complete = 1'b0;
		case (i_kind)
			`CEAU_K_MISS: begin
				o_exc_code = i_loop ? `CEAU_C_LOOP : (i_wr ? `CEAU_C_TLBW : `CEAU_C_TLBR); // RL9
				o_miss_vec = ~i_loop; // RL24
			end
			`CEAU_K_INV:
				o_exc_code = i_loop ? `CEAU_C_LOOP : (i_wr ? `CEAU_C_TLBW : `CEAU_C_TLBR); // RL9
			`CEAU_K_PROT:
				o_exc_code = i_loop ? `CEAU_C_PROL : (i_wr ? `CEAU_C_PROW : `CEAU_C_PROR); // RL10
			`CEAU_K_ADDR:
				o_exc_code = i_loop ? `CEAU_C_LOOP : (i_wr ? `CEAU_C_ADRW : `CEAU_C_ADRR); // RL11
			`CEAU_K_IPW:
				o_exc_code = `CEAU_C_IPW; // RL10
			`CEAU_K_TRAP: begin
				o_exc_code = `CEAU_C_TRAP; // RL11
				o_complete = 1'b1;
			end
			`CEAU_K_ILL:
				o_exc_code = `CEAU_C_ILL; // RL12
			`CEAU_K_SLOT:
				o_exc_code = `CEAU_C_SLOT; // RL12
			`CEAU_K_UBRK:
				o_exc_code = `CEAU_C_UBRK; // RL12
			`CEAU_K_DMA: begin
				o_exc_code = `CEAU_C_DMA; // RL12
				o_complete = 1'b1;
			end
			default:
				o_exc_code = `CEAU_C_ILL;
		endcase
	end
endmodule // ceau_code

/* src/ceau_top.v */
// Exception acceptance unit: ranks resets, exceptions and interrupts,
// records event codes, keeps status, saved PC/status and event registers.
// Assumes an in-order pipeline on i_clk presenting one instruction boundary
// at a time, and an interrupt controller that holds requests until acked.
`timescale 1ns/1ps
`include "ceau_map.vh"
module ceau_top (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_rst_n,
	// Reset pins and debug reset
	input  wire        i_pon_rst_n,
	input  wire        i_man_rst_n,
	input  wire        i_dbg_rst,
	input  wire        i_mem_busy,
	// Decode-stage boundary
	input  wire        i_dec_valid,
	input  wire [31:0] i_dec_pc,
	input  wire [31:0] i_dec_next_pc,
	input  wire        i_dec_exc,
	input  wire [3:0]  i_dec_kind,
	input  wire        i_dec_wr,
	input  wire        i_dec_loop,
	input  wire [7:0]  i_dec_imm,
	input  wire        i_dec_dbr,
	input  wire        i_dec_dbr_cond,
	input  wire        i_dec_cond_true,
	input  wire        i_dec_rte,
	// Core state
	input  wire [31:0] i_vector_base,
	input  wire        i_sr_wr,
	input  wire [31:0] i_sr_wdata,
	// Interrupt controller
	input  wire        i_nmi_req,
	input  wire        i_irq_req,
	input  wire [3:0]  i_irq_level,
	input  wire        i_irq_use_prio,
	input  wire [11:0] i_irq_prio_code,
	input  wire        i_dbgi_req,
	// Control area register port
	input  wire        i_reg_req,
	input  wire        i_reg_we,
	input  wire        i_reg_priv,
	input  wire [31:0] i_reg_addr,
	input  wire [31:0] i_reg_wdata,
	output reg  [31:0] o_reg_rdata,
	output reg         o_reg_ack,
	output reg         o_reg_err,
	// Flow control to the core
	output reg         o_pc_load,
	output reg  [31:0] o_pc_target,
	output reg         o_cpu_reinit,
	output reg  [31:0] o_sr,
	output reg  [31:0] o_spc,
	output reg  [31:0] o_ssr,
	// Interrupt acknowledge
	output reg         o_irq_ack,
	output reg  [1:0]  o_irq_src
);
	// ****************
	// Pin synchronisers
	// ****************
	reg pon_s1_q;
	reg pon_s2_q;
	reg man_s1_q;
	reg man_s2_q;

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			pon_s1_q <= 1'b1;
			pon_s2_q <= 1'b1;
			man_s1_q <= 1'b1;
			man_s2_q <= 1'b1;
		end else begin
			pon_s1_q <= i_pon_rst_n;
			pon_s2_q <= pon_s1_q;
			man_s1_q <= i_man_rst_n;
			man_s2_q <= man_s1_q;
		end
	end

	// ****************
	// State
	// ****************
	reg [11:0] exception_event_code_q;
	reg [11:0] interrupt_event_code_q;
	reg [11:0] interrupt_event_code_second_q;
	reg [7:0]  tra_q;
	reg        slot_q;
	reg [31:0] brpc_q;

	wire [11:0] exc_code;
	wire        miss_vec;
	wire        complete;
	wire [11:0] lvl_code;

	ceau_code u_code (
		.i_kind     (i_dec_kind),
		.i_wr       (i_dec_wr),
		.i_loop     (i_dec_loop),
		.i_level    (i_irq_level),
		.o_exc_code (exc_code),
		.o_miss_vec (miss_vec),
		.o_complete (complete),
		.o_lvl_code (lvl_code)
	);

	// ****************
	// Arbitration
	// ****************
	wire pon_req;
	wire man_req;
	wire take_rst;
	wire take_exc;
	wire int_open;
	wire take_nmi;
	wire take_dbgi;
	wire take_irq;
	wire take_int;
	wire take_rte;
	wire bl;
	wire [31:0] save_pc;

	assign bl       = o_sr[`CEAU_SR_BL];
	assign pon_req  = ~pon_s2_q | i_dbg_rst;
	// Manual reset lets the running memory access finish first
	assign man_req  = ~man_s2_q & ~i_mem_busy;
	assign take_rst = pon_req | man_req; // RL1
	// Kind is one code per instruction, so the three decode faults never collide
	assign take_exc = ~take_rst & i_dec_valid & i_dec_exc; // RL2 RL3 RL4 RL5
	// Interrupts wait while blocked or between a branch and its slot
	assign int_open = ~take_rst & i_dec_valid & ~i_dec_exc & ~bl & ~slot_q; // RL5 RL14 RL16
	assign take_nmi = int_open & i_nmi_req; // RL1
	assign take_dbgi = int_open & ~i_nmi_req & i_dbgi_req;
	assign take_irq = int_open & ~i_nmi_req & ~i_dbgi_req & i_irq_req;
	assign take_int = take_nmi | take_dbgi | take_irq;
	assign take_rte = ~take_rst & i_dec_valid & ~i_dec_exc & ~take_int & i_dec_rte;
	// Slot fault re-executes from the branch itself
	assign save_pc = slot_q ? brpc_q : (complete ? i_dec_next_pc : i_dec_pc); // RL6

	// ****************
	// Event flow
	// ****************
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_sr         <= `CEAU_SR_RST;
			o_spc        <= 32'h00000000;
			o_ssr        <= 32'h00000000;
			o_pc_load    <= 1'b0;
			o_pc_target  <= `CEAU_VEC_RST;
			o_cpu_reinit <= 1'b0;
			o_irq_ack    <= 1'b0;
			o_irq_src    <= 2'h0;
			slot_q       <= 1'b0;
			brpc_q       <= 32'h00000000;
		end else begin
			o_pc_load    <= 1'b0;
			o_cpu_reinit <= 1'b0;
			o_irq_ack    <= 1'b0;
			if (i_sr_wr)
				o_sr <= i_sr_wdata;
			if (i_dec_valid) begin
				slot_q <= i_dec_dbr & (~i_dec_dbr_cond | i_dec_cond_true); // RL7
				brpc_q <= i_dec_pc;
			end
			if (take_rst) begin
				o_sr         <= `CEAU_SR_RST; // RL8
				o_pc_load    <= 1'b1;
				o_pc_target  <= `CEAU_VEC_RST; // RL24
				o_cpu_reinit <= 1'b1;
				slot_q       <= 1'b0;
			end else if (take_exc && bl) begin
				// Nested fault: core restarts, event registers are kept
				o_sr         <= `CEAU_SR_RST; // RL15
				o_pc_load    <= 1'b1;
				o_pc_target  <= `CEAU_VEC_RST; // RL15
				o_cpu_reinit <= 1'b1; // RL15
				slot_q       <= 1'b0;
			end else if (take_exc) begin
				o_spc       <= save_pc; // RL23
				o_ssr       <= o_sr; // RL23
				o_sr        <= o_sr | `CEAU_SR_ENTRY; // RL23
				o_pc_load   <= 1'b1;
				o_pc_target <= i_vector_base + (miss_vec ? `CEAU_OFF_MISS : `CEAU_OFF_GEN); // RL24
				slot_q      <= 1'b0;
			end else if (take_int) begin
				o_spc       <= i_dec_pc; // RL23
				o_ssr       <= o_sr; // RL23
				o_sr        <= o_sr | `CEAU_SR_ENTRY; // RL23
				o_pc_load   <= 1'b1;
				o_pc_target <= i_vector_base + `CEAU_OFF_IRQ; // RL24
				o_irq_ack   <= 1'b1;
				o_irq_src   <= take_nmi ? 2'h2 : (take_dbgi ? 2'h1 : 2'h0);
				slot_q      <= 1'b0;
			end else if (take_rte) begin
				o_sr        <= o_ssr; // RL17
				o_pc_load   <= 1'b1;
				o_pc_target <= o_spc; // RL17
			end
		end
	end

	// ****************
	// Event registers
	// ****************
	wire hit_tra;
	wire hit_exp;
	wire hit_int;
	wire hit_int2;
	wire hit;
	wire sw_wr;

	assign hit_tra  = i_reg_addr == `CEAU_ADR_TRA;
	assign hit_exp  = i_reg_addr == `CEAU_ADR_EXP;
	assign hit_int  = i_reg_addr == `CEAU_ADR_INT;
	assign hit_int2 = i_reg_addr == `CEAU_ADR_INT2;
	assign hit      = hit_tra | hit_exp | hit_int | hit_int2;
	assign sw_wr    = i_reg_req & i_reg_we & i_reg_priv; // RL18

	// Software write first; a hardware event in the same cycle overrides it
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			exception_event_code_q  <= `CEAU_C_PON; // RL8
			interrupt_event_code_q  <= 12'h000;
			interrupt_event_code_second_q <= 12'h000;
			tra_q     <= 8'h00;
		end else begin
			if (sw_wr && hit_exp)
				exception_event_code_q <= i_reg_wdata[11:0]; // RL19
			if (sw_wr && hit_int)
				interrupt_event_code_q <= i_reg_wdata[11:0]; // RL20
			if (sw_wr && hit_tra)
				tra_q <= i_reg_wdata[9:2]; // RL22
			if (take_rst) begin
				exception_event_code_q <= pon_req ? `CEAU_C_PON : `CEAU_C_MAN; // RL8 RL19
			end else if (take_exc && !bl) begin
				exception_event_code_q <= exc_code; // RL19
				if (i_dec_kind == `CEAU_K_TRAP)
					tra_q <= i_dec_imm; // RL22
			end else if (take_nmi) begin
				interrupt_event_code_q  <= `CEAU_C_NMI; // RL13
				interrupt_event_code_second_q <= `CEAU_C_NMI; // RL21
			end else if (take_dbgi) begin
				interrupt_event_code_q  <= `CEAU_C_DBGI; // RL13
				interrupt_event_code_second_q <= `CEAU_C_DBGI; // RL21
			end else if (take_irq) begin
				interrupt_event_code_q  <= i_irq_use_prio ? i_irq_prio_code : lvl_code; // RL20
				interrupt_event_code_second_q <= lvl_code; // RL21
			end
		end
	end

	// ****************
	// Register port
	// ****************
	// Answer one cycle after the request; unprivileged or unmapped gives error
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_reg_ack   <= 1'b0;
			o_reg_err   <= 1'b0;
			o_reg_rdata <= 32'h00000000;
		end else begin
			o_reg_ack   <= i_reg_req;
			o_reg_err   <= i_reg_req & (~i_reg_priv | ~hit); // RL18
			o_reg_rdata <= 32'h00000000;
			if (i_reg_req && i_reg_priv && !i_reg_we) begin
				if (hit_tra)
					o_reg_rdata <= {22'h000000, tra_q, 2'h0}; // RL22
				else if (hit_exp)
					o_reg_rdata <= {20'h00000, exception_event_code_q}; // RL19
				else if (hit_int)
					o_reg_rdata <= {20'h00000, interrupt_event_code_q};
				else if (hit_int2)
					o_reg_rdata <= {20'h00000, interrupt_event_code_second_q};
			end
		end
	end
endmodule // ceau_top

/* verification/ceau_irq_model.sv */
// Interrupt controller stand-in for the exception acceptance unit.
// Assumes one-cycle acks that carry the accepted source code.
`timescale 1ns/1ps
module ceau_irq_model (
	// Clock and reset
	input  wire       i_clk,
	input  wire       i_rst_n,
	// Requests and acks
	input  wire [2:0] i_raise,
	input  wire       i_ack,
	input  wire [1:0] i_src,
	output reg  [2:0] o_req
);
	// ****************
	// Request holding
	// ****************
	// Held until acked, or a masked request would be lost; bit 2 NMI, 1 debug, 0 ext
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_req <= 3'h0;
		end else begin
			o_req <= (o_req | i_raise) & ~({2'h0, i_ack} << i_src);
		end
	end
endmodule // ceau_irq_model

/* verification/ceau_monitor.sv */
// Checker for the exception acceptance unit, bound to its top.
// Assumes pin resets never coincide with a boundary.
`timescale 1ns/1ps
`include "ceau_map.vh"
module ceau_monitor (
	input wire        i_clk,
	input wire        i_rst_n,
	input wire        i_dec_valid,
	input wire        i_dec_exc,
	input wire [3:0]  i_dec_kind,
	input wire        i_dec_loop,
	input wire [31:0] i_vector_base,
	input wire        i_reg_req,
	input wire        i_reg_priv,
	input wire [31:0] o_reg_rdata,
	input wire        o_reg_ack,
	input wire        o_reg_err,
	input wire        o_pc_load,
	input wire [31:0] o_pc_target,
	input wire        o_cpu_reinit,
	input wire [31:0] o_sr,
	input wire        o_irq_ack,
	input wire [31:0] o_ssr
);
	// *******
	// Checks
	// *******
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	wire blk = o_sr[`CEAU_SR_BL];
	wire exc_in = i_dec_valid && i_dec_exc;
	a_reg_answer: assert property (i_reg_req |=> o_reg_ack)
		else $error("no register ack");
	a_unpriv_refused: assert property (i_reg_req && !i_reg_priv |=> o_reg_err && o_reg_rdata == 32'h0)
		else $error("unprivileged access not refused");
	a_miss_vector: assert property (exc_in && !blk && i_dec_kind == 4'h0 && !i_dec_loop |=>
		o_pc_load && o_pc_target == $past(i_vector_base) + `CEAU_OFF_MISS) else $error("bad miss vector");
	a_accept_saves: assert property (exc_in && !blk |=> o_ssr == $past(o_sr) && o_sr[30:28] == 3'h7)
		else $error("status not saved");
	a_nested_reinit: assert property (exc_in && blk |=> o_cpu_reinit && o_pc_target == `CEAU_VEC_RST)
		else $error("nested fault not reinit");
	a_irq_masked: assert property (o_irq_ack |-> !$past(blk))
		else $error("interrupt taken while blocked");
	a_irq_vector: assert property (o_irq_ack |-> blk && o_pc_target == $past(i_vector_base, 1) + 32'h600)
		else $error("bad interrupt vector");
	a_exc_first: assert property (exc_in |=> !o_irq_ack)
		else $error("interrupt beat exception");
endmodule // ceau_monitor
bind ceau_top ceau_monitor u_mon (.*);

/* verification/tb_top.sv */
// Self-checking bench for the exception acceptance unit.
// Assumes the interrupt stand-in and the bound checker alongside.
`timescale 1ns/1ps
`include "ceau_map.vh"
module tb_top;
	logic        i_clk, i_rst_n = 0, i_pon_rst_n = 1, i_man_rst_n = 1, i_dbg_rst = 0, i_mem_busy = 0;
	logic        i_dec_valid = 0, i_dec_exc = 0, i_dec_wr = 0, i_dec_loop = 0, i_dec_dbr = 0, i_sr_wr = 0;
	logic        i_dec_dbr_cond = 0, i_dec_cond_true = 0, i_dec_rte = 0, i_irq_use_prio = 0;
	logic        i_reg_req = 0, i_reg_we = 0, i_reg_priv = 0;
	logic [2:0]  raise = 0;
	logic [3:0]  i_dec_kind = 0, i_irq_level = 0;
	logic [7:0]  i_dec_imm = 8'ha5;
	logic [11:0] i_irq_prio_code = 0;
	logic [31:0] i_dec_pc = 32'h8c001000, i_vector_base = 32'h8c000000, i_sr_wdata = 0, i_reg_addr = 0;
	logic [31:0] i_reg_wdata = 0;
	wire  [31:0] i_dec_next_pc = i_dec_pc + 32'h2;
	wire         i_nmi_req, i_irq_req, i_dbgi_req, o_reg_ack, o_reg_err, o_pc_load, o_cpu_reinit, o_irq_ack;
	wire  [1:0]  o_irq_src;
	wire  [31:0] o_reg_rdata, o_pc_target, o_sr, o_spc, o_ssr;
	int          errors = 0, check_count = 0;
	// Kind, write, loop, expected code
	logic [17:0] tbl [16] = '{18'h00040, 18'h02060, 18'h01070, 18'h06060, 18'h080a0, 18'h0a0c0, 18'h090d0,
		18'h0c0e0, 18'h0e100, 18'h0d070, 18'h12080, 18'h14160, 18'h18180, 18'h1c1a0, 18'h201e0, 18'h245c0};

	ceau_top DUT (.*);
	ceau_irq_model u_irq (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_raise(raise), .i_ack(o_irq_ack),
		.i_src(o_irq_src), .o_req({i_nmi_req, i_dbgi_req, i_irq_req}));

	// ******
	// Tasks
	// ******
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e, input logic ee);
		@(negedge i_clk);
		{i_reg_req, i_reg_we, i_reg_addr, i_reg_wdata} = {1'b1, w, a, d};
		@(negedge i_clk);
		i_reg_req = 0;
		chk(o_reg_ack, 1);
		chk(o_reg_err, ee);
		if (!w) chk(o_reg_rdata, e);
	endtask

	task step(input logic x, input logic [3:0] k, input logic w, input logic l);
		@(negedge i_clk);
		{i_dec_valid, i_dec_exc, i_dec_kind, i_dec_wr, i_dec_loop} = {1'b1, x, k, w, l};
		i_dec_pc = i_dec_pc + 32'h2;
		@(negedge i_clk);
		{i_dec_valid, i_dec_exc, i_dec_dbr, i_dec_dbr_cond, i_dec_cond_true, i_dec_rte} = 6'h0;
	endtask

	task clr;
		@(negedge i_clk);
		i_sr_wr = 1;
		@(negedge i_clk);
		i_sr_wr = 0;
	endtask

	task up(input logic [2:0] m);
		@(negedge i_clk);
		raise = m;
		@(negedge i_clk);
		raise = 0;
	endtask

	task t_codes;
		logic [11:0] c;
		for (int i = 0; i < 16; i++) begin
			c = tbl[i][11:0];
			clr;
			step(1, tbl[i][17:14], tbl[i][13], tbl[i][12]);
			chk(o_pc_target, i_vector_base + (tbl[i][17:14] == 4'h0 && !tbl[i][12] ? 32'h400 : 32'h100));
			chk(o_spc, i_dec_pc + (c == 12'h160 || c == 12'h5c0 ? 32'h2 : 32'h0));
			acc(0, 32'h0fffffd4, 0, {20'h0, c}, 0);
		end
		acc(0, 32'h0fffffd0, 0, 32'h294, 0);
		step(1, 4'h6, 0, 0);
		chk(o_pc_target, 32'ha0000000);
		acc(0, 32'h0fffffd4, 0, 32'h5c0, 0);
	endtask

	task t_return;
		logic [31:0] p;
		clr;
		step(1, 4'h6, 0, 0);
		p = i_dec_pc;
		@(negedge i_clk);
		i_dec_rte = 1;
		step(0, 4'h0, 0, 0);
		chk(o_pc_target, p);
		chk(o_sr, 32'h0);
	endtask

	task t_irq;
		logic [31:0] e;
		i_irq_level = 4'he;
		i_irq_prio_code = 12'h3a5;
		step(1, 4'h6, 0, 0);
		up(3'h7);
		step(0, 4'h0, 0, 0);
		chk(o_irq_ack, 0);
		for (int s = 2; s >= 0; s--) begin
			e = s == 2 ? 32'h1c0 : s == 1 ? 32'h5e0 : 32'h200 + 32'h20 * i_irq_level;
			i_irq_use_prio = s == 0;
			clr;
			step(0, 4'h0, 0, 0);
			chk(o_irq_ack, 1);
			chk(o_irq_src, s);
			chk(o_pc_target, i_vector_base + 32'h600);
			acc(0, 32'h04000000, 0, e, 0);
			acc(0, 32'h0fffffd8, 0, s == 0 ? 32'h3a5 : e, 0);
		end
	endtask

	task t_reg;
		i_reg_priv = 0;
		acc(0, 32'h0fffffd4, 0, 0, 1);
		acc(1, 32'h0fffffd4, 32'h123, 0, 1);
		i_reg_priv = 1;
		acc(0, 32'h0fffffd4, 0, 32'h180, 0);
		acc(0, 32'h0fffffdc, 0, 0, 1);
		acc(1, 32'h0fffffd4, 32'hffffffff, 0, 0);
		acc(0, 32'h0fffffd4, 0, 32'hfff, 0);
		acc(1, 32'h0fffffd0, 32'hffffffff, 0, 0);
		acc(0, 32'h0fffffd0, 0, 32'h3fc, 0);
		acc(1, 32'h0fffffd8, 32'h5a, 0, 0);
		acc(0, 32'h0fffffd8, 0, 32'h5a, 0);
		acc(1, 32'h04000000, 32'h0, 0, 0);
		acc(0, 32'h04000000, 0, 32'h3c0, 0);
	endtask

	task t_slot;
		logic [31:0] p;
		clr;
		{i_dec_dbr, i_dec_dbr_cond} = 2'h3;
		step(0, 4'h0, 0, 0);
		up(3'h4);
		step(0, 4'h0, 0, 0);
		chk(o_irq_ack, 1);
		clr;
		i_dec_dbr = 1;
		step(0, 4'h0, 0, 0);
		up(3'h4);
		step(0, 4'h0, 0, 0);
		chk(o_irq_ack, 0);
		step(0, 4'h0, 0, 0);
		chk(o_irq_ack, 1);
		clr;
		{i_dec_dbr, i_dec_dbr_cond, i_dec_cond_true} = 3'h7;
		step(0, 4'h0, 0, 0);
		p = i_dec_pc;
		up(3'h4);
		step(1, 4'h6, 0, 0);
		chk(o_spc, p);
		clr;
		step(1, 4'h6, 0, 0);
		chk(o_irq_ack, 0);
		clr;
		step(0, 4'h0, 0, 0);
		chk(o_irq_ack, 1);
	endtask

	task t_rst;
		@(negedge i_clk);
		i_man_rst_n = 0;
		repeat (4) @(negedge i_clk);
		chk(o_cpu_reinit, 1);
		i_man_rst_n = 1;
		repeat (3) @(negedge i_clk);
		chk(o_pc_target, 32'ha0000000);
		acc(0, 32'h0fffffd4, 0, 32'h20, 0);
		@(negedge i_clk);
		i_dbg_rst = 1;
		@(negedge i_clk);
		i_dbg_rst = 0;
		acc(0, 32'h0fffffd4, 0, 32'h0, 0);
	endtask

	task wrap_up;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		i_clk = 0;
		forever #25 i_clk = ~i_clk;
	end

	// Whole run needs under a thousand cycles
	initial begin
		repeat (5000) @(posedge i_clk);
		errors++;
		wrap_up;
	end

	initial begin
		repeat (8) @(negedge i_clk);
		i_rst_n = 1;
		i_reg_priv = 1;
		t_codes;
		t_return;
		t_irq;
		t_reg;
		t_slot;
		t_rst;
		wrap_up;
	end
endmodule // tb_top
